// [design/rfc_top.sv]
// rf configuration command handler with axi4-lite register access
// Function
// - frame D4 32, item byte, item payload
// - item 01: bit0 field, bit1 collision avoid
// - no avoidance: field on regardless external
// - item 02: reserved, activation, exchange timeouts
// - no activation answer in timeout: mute
// - exchange timeout expiry abandons reception
// - code 0 none, else 100us times 2^(n-1)
// - item 04: comm retry limit, default 00
// - item 05: activation, selection, passive retries
// - active activation retries, default FF
// - passive mode always uses two retries
// - parameter selection retries, default 01
// - passive listing retries, default FF
// - item 0A: eleven analog bytes in order
// - analog defaults 5A F4 ... 87
// - demod setting follows own field state
// - timing byte above 10: syntax error
// - bad item or length: syntax error
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module rfc_top #(
  parameter int TICK_CYCLES_P = rfc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  // axi4-lite slave
  input  wire logic [7:0]         s_axi_awaddr_in,
  input  wire logic               s_axi_awvalid_in,
  output logic                    s_axi_awready_out,
  input  wire logic [31:0]        s_axi_wdata_in,
  input  wire logic [3:0]         s_axi_wstrb_in,
  input  wire logic               s_axi_wvalid_in,
  output logic                    s_axi_wready_out,
  output logic [1:0]              s_axi_bresp_out,
  output logic                    s_axi_bvalid_out,
  input  wire logic               s_axi_bready_in,
  input  wire logic [7:0]         s_axi_araddr_in,
  input  wire logic               s_axi_arvalid_in,
  output logic                    s_axi_arready_out,
  output logic [31:0]             s_axi_rdata_out,
  output logic [1:0]              s_axi_rresp_out,
  output logic                    s_axi_rvalid_out,
  input  wire logic               s_axi_rready_in,
  // radio side
  input  wire logic               ext_field_in,
  input  wire logic               passive_mode_in,
  input  wire logic               act_start_in,
  input  wire logic               act_answer_in,
  input  wire logic               exch_start_in,
  input  wire logic               exch_answer_in,
  output logic                    field_switch_out,
  output logic                    auto_collision_avoid_out,
  output logic [7:0]              demod_setting_out,
  output logic [87:0]             analog_cfg_out,
  output rfc_pkg::rfc_retry_t     retry_out,
  output logic                    act_mute_out,
  output logic                    exch_giveup_out,
  output logic                    irq_out
);
  logic [1:0] rst_sync_q;
  logic       rst_n;
  rfc_pkg::rfc_state_t st_q;
  logic [7:0]  buf_q [16];
  logic [4:0]  cnt_q;
  logic        ovf_q;
  logic [7:0]  item;
  logic        err_c;
  logic        err_q;
  logic [15:0] rsp_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic        field_req_q;
  logic [87:0] ana_q;
  rfc_pkg::rfc_timing_t tmo_q;
  rfc_pkg::rfc_retry_t  rty_q;
  logic [25:0] act_cnt_q;
  logic        act_run_q;
  logic [25:0] exc_cnt_q;
  logic        exc_run_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wr_go;
  logic [31:0] rd_c;
  logic        rd_ok;
  logic        wr_ok;
  logic        ok_dec;
  // timeout code to cycles; callers guard code zero
  function automatic logic [25:0] tmo_cycles(input logic [7:0] code);
    tmo_cycles = 26'(TICK_CYCLES_P) << (code - 8'h01);
  endfunction
  // register map check, shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a <= rfc_pkg::A_ANA2);
  endfunction
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) rst_sync_q <= 2'b00;
    else            rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];
  // write channel: address and data taken in either order
  assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid_out;
  assign wr_ok = addr_mapped(awaddr_q);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q          <= 1'b0;
      w_got_q           <= 1'b0;
      awaddr_q          <= 8'h00;
      wdata_q           <= 32'h0000_0000;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= rfc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_q          <= 1'b1;
        awaddr_q          <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end else if (!aw_got_q && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_q          <= 1'b1;
        wdata_q          <= s_axi_wstrb_in[0] ? s_axi_wdata_in : 32'h0000_0000;
        s_axi_wready_out <= 1'b0;
      end else if (!w_got_q && !s_axi_bvalid_out) begin
        s_axi_wready_out <= 1'b1;
      end
      if (wr_go) begin
        aw_got_q         <= 1'b0;
        w_got_q          <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_ok ? rfc_pkg::RESP_OKAY : rfc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end
  // read data mux; reserved bits read zero
  assign rd_ok = addr_mapped(s_axi_araddr_in);
  always_comb begin
    rd_c = 32'h0000_0000;
    case (s_axi_araddr_in)
      rfc_pkg::A_STATUS:   rd_c = {22'h0, err_q, ovf_q, st_q, 1'b0, cnt_q};
      rfc_pkg::A_RESP:     rd_c = {16'h0, rsp_q};
      rfc_pkg::A_IRQ_STAT: rd_c = {30'h0, irq_stat_q};
      rfc_pkg::A_IRQ_MASK: rd_c = {30'h0, irq_mask_q};
      rfc_pkg::A_FIELD:    rd_c = {29'h0, field_switch_out, auto_collision_avoid_out, field_req_q};
      rfc_pkg::A_TIMING:   rd_c = {16'h0, tmo_q};
      rfc_pkg::A_RETRY:    rd_c = rty_q;
      rfc_pkg::A_ANA0:     rd_c = ana_q[31:0];
      rfc_pkg::A_ANA1:     rd_c = ana_q[63:32];
      rfc_pkg::A_ANA2:     rd_c = {8'h00, ana_q[87:64]};
      default:             rd_c = 32'h0000_0000;
    endcase
  end
  // read channel: answer one cycle after the address is taken
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= rfc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_ok ? rd_c : 32'h0000_0000;
      s_axi_rresp_out   <= rd_ok ? rfc_pkg::RESP_OKAY : rfc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end else if (!s_axi_rvalid_out) begin
      s_axi_arready_out <= 1'b1;
    end
  end
  // frame buffer: bytes pushed one per write while idle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      ovf_q <= 1'b0;
      for (int i = 0; i < 16; i++) buf_q[i] <= 8'h00;
    end else if (st_q == rfc_pkg::ST_REPLY) begin
      cnt_q <= 5'h00;
      ovf_q <= 1'b0;
    end else if (wr_go && st_q == rfc_pkg::ST_IDLE) begin
      if (awaddr_q == rfc_pkg::A_CTRL && wdata_q[rfc_pkg::CTRL_FLUSH]) begin
        cnt_q <= 5'h00;
        ovf_q <= 1'b0;
      end else if (awaddr_q == rfc_pkg::A_CMD_DATA) begin
        if (cnt_q == rfc_pkg::BUF_DEPTH) begin
          ovf_q <= 1'b1; // too long frames end as a length error
        end else begin
          buf_q[cnt_q[3:0]] <= wdata_q[7:0];
          cnt_q             <= cnt_q + 5'h01;
        end
      end
    end
  end
  // command check: header, item and length
  assign item = buf_q[2];
  always_comb begin
    err_c = (cnt_q < rfc_pkg::LEN_HDR) || ovf_q || (buf_q[0] != rfc_pkg::CLASS_CMD) ||
            (buf_q[1] != rfc_pkg::CODE_CMD);
    case (item)
      rfc_pkg::ITEM_FIELD:  err_c = err_c || cnt_q != rfc_pkg::LEN_FIELD;
      rfc_pkg::ITEM_TIMING: err_c = err_c || cnt_q != rfc_pkg::LEN_TIMING ||
                                    buf_q[4] > rfc_pkg::TMO_MAX || buf_q[5] > rfc_pkg::TMO_MAX;
      rfc_pkg::ITEM_COMM:   err_c = err_c || cnt_q != rfc_pkg::LEN_COMM;
      rfc_pkg::ITEM_RETRY:  err_c = err_c || cnt_q != rfc_pkg::LEN_RETRY;
      rfc_pkg::ITEM_ANA_A:  err_c = err_c || cnt_q != rfc_pkg::LEN_ANA_A;
      rfc_pkg::ITEM_ANA_HI: err_c = err_c || cnt_q != rfc_pkg::LEN_ANA_HI;
      rfc_pkg::ITEM_ANA_B:  err_c = err_c || cnt_q != rfc_pkg::LEN_ANA_B;
      rfc_pkg::ITEM_ANA_4:  err_c = err_c || cnt_q != rfc_pkg::LEN_ANA_4;
      default:              err_c = 1'b1;
    endcase
  end
  assign ok_dec = (st_q == rfc_pkg::ST_DECODE) && !err_c;
  // command sequencer
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= rfc_pkg::ST_IDLE;
      err_q <= 1'b0;
      rsp_q <= 16'h0000;
    end else begin
      case (st_q)
        rfc_pkg::ST_IDLE: begin
          if (wr_go && awaddr_q == rfc_pkg::A_CTRL && wdata_q[rfc_pkg::CTRL_EXEC] &&
              !wdata_q[rfc_pkg::CTRL_FLUSH]) begin
            st_q <= rfc_pkg::ST_DECODE;
            rsp_q <= 16'h0000;
          end
        end
        rfc_pkg::ST_DECODE: begin
          err_q <= err_c;
          rsp_q <= err_c ? 16'h0000 : {rfc_pkg::CODE_RSP, rfc_pkg::CLASS_RSP};
          st_q  <= rfc_pkg::ST_REPLY;
        end
        rfc_pkg::ST_REPLY: st_q <= rfc_pkg::ST_IDLE;
        default:           st_q <= rfc_pkg::ST_IDLE;
      endcase
    end
  end
  // sticky interrupt causes; a new event beats a same-cycle clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
      irq_out    <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_go && awaddr_q == rfc_pkg::A_IRQ_STAT) ? wdata_q[1:0] : 2'b00)) |
                    {st_q == rfc_pkg::ST_DECODE && err_c, ok_dec};
      if (wr_go && awaddr_q == rfc_pkg::A_IRQ_MASK) irq_mask_q <= wdata_q[1:0];
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  // field control; without avoidance the external field is not consulted
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      field_req_q              <= 1'b0;
      auto_collision_avoid_out <= 1'b0;
      field_switch_out         <= 1'b0;
    end else begin
      if (ok_dec && item == rfc_pkg::ITEM_FIELD) begin
        field_req_q              <= buf_q[3][0];
        auto_collision_avoid_out <= buf_q[3][1];
      end
      field_switch_out <= field_req_q && (!auto_collision_avoid_out || !ext_field_in);
    end
  end

  // timing and retry settings
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tmo_q <= '{act: rfc_pkg::DEF_ACT_TMO, exch: rfc_pkg::DEF_EXC_TMO};
      rty_q <= '{comm: rfc_pkg::DEF_COMM, atr: rfc_pkg::DEF_ATR,
                 psl: rfc_pkg::DEF_PSL, pas: rfc_pkg::DEF_PAS};
    end else if (ok_dec) begin
      if (item == rfc_pkg::ITEM_TIMING) tmo_q <= '{act: buf_q[4], exch: buf_q[5]};
      if (item == rfc_pkg::ITEM_COMM) rty_q.comm <= buf_q[3];
      if (item == rfc_pkg::ITEM_RETRY) begin
        rty_q.atr <= buf_q[3];
        rty_q.psl <= buf_q[4];
        rty_q.pas <= buf_q[5];
      end
    end
  end

  // retry limits to the protocol engine; passive mode overrides activation
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      retry_out <= '{comm: rfc_pkg::DEF_COMM, atr: rfc_pkg::DEF_ATR,
                     psl: rfc_pkg::DEF_PSL, pas: rfc_pkg::DEF_PAS};
    end else begin
      retry_out     <= rty_q;
      retry_out.atr <= passive_mode_in ? rfc_pkg::PASSIVE_ATR : rty_q.atr;
    end
  end

  // analog presets, byte one in the low lane
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ana_q <= rfc_pkg::ANA_DEF;
    end else if (ok_dec && item == rfc_pkg::ITEM_ANA_A) begin
      for (int i = 0; i < rfc_pkg::ANA_BYTES; i++) ana_q[i*8 +: 8] <= buf_q[i+3];
    end
  end

  // analog outputs; demod copy tracks the live field state
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      analog_cfg_out    <= rfc_pkg::ANA_DEF;
      demod_setting_out <= 8'h00;
    end else begin
      analog_cfg_out    <= ana_q;
      demod_setting_out <= field_switch_out ? ana_q[rfc_pkg::ANA_DEMOD_ON*8 +: 8]
                                            : ana_q[rfc_pkg::ANA_DEMOD_OFF*8 +: 8];
    end
  end

  // activation answer watchdog; code zero never expires
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      act_run_q    <= 1'b0;
      act_cnt_q    <= 26'h0;
      act_mute_out <= 1'b0;
    end else begin
      act_mute_out <= 1'b0;
      if (act_start_in) begin
        act_run_q <= tmo_q.act != 8'h00;
        act_cnt_q <= tmo_cycles(tmo_q.act);
      end else if (act_run_q) begin
        if (act_answer_in) begin
          act_run_q <= 1'b0;
        end else if (act_cnt_q == 26'h1) begin
          act_run_q    <= 1'b0;
          act_mute_out <= 1'b1;
        end else begin
          act_cnt_q <= act_cnt_q - 26'h1;
        end
      end
    end
  end

  // exchange answer watchdog, same shape as activation
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      exc_run_q       <= 1'b0;
      exc_cnt_q       <= 26'h0;
      exch_giveup_out <= 1'b0;
    end else begin
      exch_giveup_out <= 1'b0;
      if (exch_start_in) begin
        exc_run_q <= tmo_q.exch != 8'h00;
        exc_cnt_q <= tmo_cycles(tmo_q.exch);
      end else if (exc_run_q) begin
        if (exch_answer_in) begin
          exc_run_q <= 1'b0;
        end else if (exc_cnt_q == 26'h1) begin
          exc_run_q       <= 1'b0;
          exch_giveup_out <= 1'b1;
        end else begin
          exc_cnt_q <= exc_cnt_q - 26'h1;
        end
      end
    end
  end

  // checks
  AST_RSP_CODE: assert property (@(posedge clk_in) disable iff (!rst_n)
    ok_dec |=> rsp_q == 16'h33D5 && st_q == rfc_pkg::ST_REPLY) else $error("bad response bytes");
  AST_FIELD_NOCA: assert property (@(posedge clk_in) disable iff (!rst_n)
    (field_req_q && !auto_collision_avoid_out) |=> field_switch_out) else $error("field not on");
  AST_FIELD_APPLY: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ok_dec && item == 8'h01) |=> field_req_q == $past(buf_q[3][0])) else $error("field bit lost");
  AST_TMO_RANGE: assert property (@(posedge clk_in) disable iff (!rst_n)
    (st_q == rfc_pkg::ST_DECODE && item == 8'h02 && buf_q[5] > 8'h10) |=> err_q && irq_stat_q[1])
    else $error("timing range not refused");
  AST_BAD_ITEM: assert property (@(posedge clk_in) disable iff (!rst_n)
    (st_q == rfc_pkg::ST_DECODE && item inside {8'h00, 8'h03, 8'h06, 8'h0E}) |=> err_q && rsp_q == 16'h0)
    else $error("bad item accepted");
  AST_ATR_PASSIVE: assert property (@(posedge clk_in) disable iff (!rst_n)
    passive_mode_in |=> retry_out.atr == 8'h02) else $error("passive retries wrong");
  AST_DEMOD: assert property (@(posedge clk_in) disable iff (!rst_n)
    rst_n |=> demod_setting_out == ($past(field_switch_out) ? $past(ana_q[39:32]) : $past(ana_q[55:48])))
    else $error("demod setting mismatch");
  AST_TMO_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n)
    (exch_start_in && tmo_q.exch == 8'h00) |=> !exc_run_q [*3]) else $error("zero code timed");
  AST_ANA_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ok_dec && item == 8'h0A) |=> ana_q[7:0] == $past(buf_q[3]) && ana_q[87:80] == $past(buf_q[13]))
    else $error("analog bytes misplaced");
endmodule // rfc_top

// [design/rfc_pkg.sv]
// constants, types and register map of the rf configuration command handler
package rfc_pkg;
  // frame bytes
  localparam logic [7:0] CLASS_CMD = 8'hD4;
  localparam logic [7:0] CLASS_RSP = 8'hD5;
  localparam logic [7:0] CODE_CMD  = 8'h32;
  localparam logic [7:0] CODE_RSP  = 8'h33;
  // configuration items
  localparam logic [7:0] ITEM_FIELD  = 8'h01;
  localparam logic [7:0] ITEM_TIMING = 8'h02;
  localparam logic [7:0] ITEM_COMM   = 8'h04;
  localparam logic [7:0] ITEM_RETRY  = 8'h05;
  localparam logic [7:0] ITEM_ANA_A  = 8'h0A;
  localparam logic [7:0] ITEM_ANA_HI = 8'h0B;
  localparam logic [7:0] ITEM_ANA_B  = 8'h0C;
  localparam logic [7:0] ITEM_ANA_4  = 8'h0D;
  // whole frame lengths: header of three bytes plus payload
  localparam logic [4:0] LEN_HDR    = 5'h03;
  localparam logic [4:0] LEN_FIELD  = 5'h04;
  localparam logic [4:0] LEN_TIMING = 5'h06;
  localparam logic [4:0] LEN_COMM   = 5'h04;
  localparam logic [4:0] LEN_RETRY  = 5'h06;
  localparam logic [4:0] LEN_ANA_A  = 5'h0E;
  localparam logic [4:0] LEN_ANA_HI = 5'h0B;
  localparam logic [4:0] LEN_ANA_B  = 5'h06;
  localparam logic [4:0] LEN_ANA_4  = 5'h0C;
  localparam logic [4:0] BUF_DEPTH  = 5'h10;
  // setting limits and reset values
  localparam logic [7:0] TMO_MAX     = 8'h10;
  localparam logic [7:0] DEF_ACT_TMO = 8'h0B;
  localparam logic [7:0] DEF_EXC_TMO = 8'h0A;
  localparam logic [7:0] DEF_COMM    = 8'h00;
  localparam logic [7:0] DEF_ATR     = 8'hFF;
  localparam logic [7:0] DEF_PSL     = 8'h01;
  localparam logic [7:0] DEF_PAS     = 8'hFF;
  localparam logic [7:0] PASSIVE_ATR = 8'h02;
  localparam int         ANA_BYTES   = 11;
  localparam int         ANA_DEMOD_ON  = 4;
  localparam int         ANA_DEMOD_OFF = 6;
  localparam logic [87:0] ANA_DEF = 88'h87_62_26_6F_61_85_4D_11_3F_F4_5A;
  // timeout unit
  localparam int TICK_US     = 100;
  localparam int CLK_MHZ     = 10;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  // register byte addresses
  localparam logic [7:0] A_CMD_DATA = 8'h00;
  localparam logic [7:0] A_CTRL     = 8'h04;
  localparam logic [7:0] A_STATUS   = 8'h08;
  localparam logic [7:0] A_RESP     = 8'h0C;
  localparam logic [7:0] A_IRQ_STAT = 8'h10;
  localparam logic [7:0] A_IRQ_MASK = 8'h14;
  localparam logic [7:0] A_FIELD    = 8'h18;
  localparam logic [7:0] A_TIMING   = 8'h1C;
  localparam logic [7:0] A_RETRY    = 8'h20;
  localparam logic [7:0] A_ANA0     = 8'h24;
  localparam logic [7:0] A_ANA1     = 8'h28;
  localparam logic [7:0] A_ANA2     = 8'h2C;
  // field positions
  localparam int CTRL_EXEC  = 0;
  localparam int CTRL_FLUSH = 1;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ERR    = 1;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] act;
    logic [7:0] exch;
  } rfc_timing_t;

  typedef struct packed {
    logic [7:0] comm;
    logic [7:0] atr;
    logic [7:0] psl;
    logic [7:0] pas;
  } rfc_retry_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DECODE = 2'b01,
    ST_REPLY  = 2'b11
  } rfc_state_t;
endpackage

// [testbench/rfc_host.sv]
// host model: axi4-lite master that frames and starts commands
`timescale 1ns/10ps
module rfc_host (
  // clock
  input  wire logic        clk_in,
  // write channels
  output logic [7:0]       aw_out,
  output logic             awv_out,
  input  wire logic        awr_in,
  output logic [31:0]      wd_out,
  output logic             wv_out,
  input  wire logic        wr_in,
  input  wire logic [1:0]  br_in,
  input  wire logic        bv_in,
  output logic             by_out,
  // read channels
  output logic [7:0]       ar_out,
  output logic             arv_out,
  input  wire logic        arr_in,
  input  wire logic [31:0] rd_in,
  input  wire logic [1:0]  rr_in,
  input  wire logic        rv_in,
  output logic             ry_out
);
  // bus idle from time zero
  initial {aw_out, awv_out, wd_out, wv_out, by_out, ar_out, arv_out, ry_out} = '0;

  // write: address and data offered together, each dropped once taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    @(posedge clk_in);
    {aw_out, wd_out} <= {a, d};
    {awv_out, wv_out, by_out} <= 3'h7;
    {ta, tw} = 2'h0;
    while (!(ta && tw)) begin
      @(posedge clk_in);
      ta = ta | awr_in;
      tw = tw | wr_in;
      {awv_out, wv_out} <= {!ta, !tw};
    end
    do @(posedge clk_in); while (!bv_in);
    r = br_in;
    by_out <= 1'b0;
  endtask

  // read: address held until taken, ready held until data comes
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    ar_out <= a;
    {arv_out, ry_out} <= 2'h3;
    do @(posedge clk_in); while (!arr_in);
    arv_out <= 1'b0;
    do @(posedge clk_in); while (!rv_in);
    {d, r} = {rd_in, rr_in};
    ry_out <= 1'b0;
  endtask

  // whole frame pushed byte by byte, then executed
  task automatic send(input logic [7:0] it, input logic [7:0] pl [0:15], input int n);
    logic [1:0] r;
    logic [7:0] b;
    for (int i = 0; i < n + 3; i++) begin
      b = (i == 0) ? rfc_pkg::CLASS_CMD : (i == 1) ? rfc_pkg::CODE_CMD : (i == 2) ? it : pl[i - 3];
      wr_reg(rfc_pkg::A_CMD_DATA, {24'h000000, b}, r);
    end
    wr_reg(rfc_pkg::A_CTRL, 32'h00000001, r);
    // decode and reply need two edges after the write completes
    repeat (4) @(posedge clk_in);
  endtask
endmodule // rfc_host

// [testbench/rf_configuration_command_tb.sv]
// self-checking bench of the rf configuration command handler
`timescale 1ns/10ps
module rf_configuration_command_tb;
  localparam int TICK = 4;
  logic        clk, rstn, awv, awr, wv, wrd, bv, by, arv, arr, rv, ry, f;
  logic        ext, pas, a_go, a_ans, x_go, x_ans, fld, cav, mute, quit, irq;
  logic [7:0]  aw, ar, dem;
  logic [31:0] wd, rd, v;
  logic [1:0]  br, rr, r;
  logic [87:0] ana, ea;
  logic [15:0] tm;
  logic [7:0]  pl [0:15] = '{default: 8'h00};
  logic [7:0]  bad [0:7] = '{8'h00, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0E, 8'hFF};
  rfc_pkg::rfc_retry_t rty;
  int          error_cnt, check_count;

  rfc_top #(.TICK_CYCLES_P(TICK)) dut (.clk_in(clk), .resetn_in(rstn),
    .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(by), .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(ry), .ext_field_in(ext), .passive_mode_in(pas), .act_start_in(a_go),
    .act_answer_in(a_ans), .exch_start_in(x_go), .exch_answer_in(x_ans), .field_switch_out(fld),
    .auto_collision_avoid_out(cav), .demod_setting_out(dem), .analog_cfg_out(ana),
    .retry_out(rty), .act_mute_out(mute), .exch_giveup_out(quit), .irq_out(irq));
  rfc_host host (.clk_in(clk), .aw_out(aw), .awv_out(awv), .awr_in(awr), .wd_out(wd),
    .wv_out(wv), .wr_in(wrd), .br_in(br), .bv_in(bv), .by_out(by), .ar_out(ar),
    .arv_out(arv), .arr_in(arr), .rd_in(rd), .rr_in(rr), .rv_in(rv), .ry_out(ry));

  // 100 ns clock
  always #50 clk = ~clk;

  // compare and count
  task automatic chk(input string n, input logic [87:0] e, input logic [87:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // expiry length in clock cycles for a timeout code
  function automatic int len(input logic [7:0] n);
    return (n == 8'h00) ? 0 : TICK << (n - 8'h01);
  endfunction

  // one command, then its error flag and response word
  task automatic run(input logic [7:0] it, input int n, input logic ok);
    host.send(it, pl, n);
    host.rd_reg(rfc_pkg::A_STATUS, v, r);
    chk("error flag", !ok, v[9]);
    host.rd_reg(rfc_pkg::A_RESP, v, r);
    chk("response", {rfc_pkg::RESP_OKAY, ok ? 32'h33D5 : 32'h0000}, {r, v});
  endtask

  // start a watchdog, maybe answer it, count edges to expiry (w 0: none)
  task automatic tmo(input logic s, input logic ans, input int w);
    int k;
    @(posedge clk);
    {a_go, x_go} <= {!s, s};
    @(posedge clk);
    {a_go, x_go, a_ans, x_ans} <= {2'h0, ans & !s, ans & s};
    @(posedge clk);
    {a_ans, x_ans} <= 2'h0;
    k = 2;
    while (!(s ? quit : mute) && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk("expiry edges", 1'b1, (w == 0) ? k == 200 : (k >= w - 1 && k <= w + 2));
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #2000000;
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    {clk, rstn, ext, pas, a_go, a_ans, x_go, x_ans} = 8'h00;
    {error_cnt, check_count} = {32'h0, 32'h0};
    void'($urandom(32'h4ED92890));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("analog reset", 88'h87_62_26_6F_61_85_4D_11_3F_F4_5A, ana);
    chk("retry reset", 32'h00_FF_01_FF, rty);
    chk("demod reset", 8'h61, dem);
    host.rd_reg(rfc_pkg::A_TIMING, v, r);
    chk("timing reset", 16'h0B0A, v[15:0]);
    // every field and avoidance pairing, with and without an outside field
    for (int i = 0; i < 8; i++) begin
      pl[0] = {6'h00, i[1:0]};
      ext <= i[2];
      f = i[0] & !(i[1] & i[2]);
      run(rfc_pkg::ITEM_FIELD, 1, 1'b1);
      chk("field", f, fld);
      chk("avoid", i[1], cav);
      chk("demod", f ? 8'h4D : 8'h61, dem);
    end
    // timing codes up to the 10 limit, then over-limit bytes refused
    for (int i = 0; i < 5; i++) begin
      pl[0] = 8'($urandom);
      pl[1] = (i == 0) ? 8'h10 : 8'($urandom_range(16, 0));
      pl[2] = 8'($urandom_range(16, 0));
      tm = {pl[1], pl[2]};
      run(rfc_pkg::ITEM_TIMING, 3, 1'b1);
      host.rd_reg(rfc_pkg::A_TIMING, v, r);
      chk("timing", tm, v[15:0]);
    end
    for (int j = 1; j < 3; j++) begin
      pl[j] = 8'h11;
      run(rfc_pkg::ITEM_TIMING, 3, 1'b0);
      pl[j] = 8'h00;
      host.rd_reg(rfc_pkg::A_TIMING, v, r);
      chk("timing kept", tm, v[15:0]);
    end
    // short codes so the watchdogs expire quickly
    {pl[1], pl[2]} = 16'h0201;
    run(rfc_pkg::ITEM_TIMING, 3, 1'b1);
    tmo(1'b0, 1'b0, len(8'h02));
    tmo(1'b1, 1'b0, len(8'h01));
    tmo(1'b0, 1'b1, 0);
    {pl[1], pl[2]} = 16'h0500;
    run(rfc_pkg::ITEM_TIMING, 3, 1'b1);
    tmo(1'b0, 1'b0, len(8'h05));
    tmo(1'b1, 1'b0, 0);
    // retry limits, forever value first
    pl[0] = 8'hFF;
    run(rfc_pkg::ITEM_COMM, 1, 1'b1);
    for (int i = 0; i < 3; i++) pl[i] = 8'($urandom);
    run(rfc_pkg::ITEM_RETRY, 3, 1'b1);
    chk("retries", {8'hFF, pl[0], pl[1], pl[2]}, rty);
    pas <= 1'b1;
    repeat (2) @(posedge clk);
    chk("passive", {8'hFF, 8'h02, pl[1], pl[2]}, rty);
    pas <= 1'b0;
    // analog presets in byte order; field is off so byte 7 drives demod
    for (int i = 0; i < 11; i++) begin
      pl[i] = 8'($urandom);
      ea[i*8 +: 8] = pl[i];
    end
    run(rfc_pkg::ITEM_ANA_A, 11, 1'b1);
    chk("analog", ea, ana);
    chk("demod off", pl[6], dem);
    run(rfc_pkg::ITEM_ANA_A, 10, 1'b0);
    run(rfc_pkg::ITEM_ANA_A, 14, 1'b0);
    foreach (bad[k]) run(bad[k], 1, 1'b0);
    run(rfc_pkg::ITEM_ANA_HI, 8, 1'b1);
    run(rfc_pkg::ITEM_ANA_B, 3, 1'b1);
    run(rfc_pkg::ITEM_ANA_4, 9, 1'b1);
    chk("analog kept", ea, ana);
    // interrupt masked, raised, cleared; unmapped write refused
    host.wr_reg(rfc_pkg::A_IRQ_STAT, 32'h00000003, r);
    host.wr_reg(rfc_pkg::A_IRQ_MASK, 32'h00000001, r);
    run(rfc_pkg::ITEM_FIELD, 2, 1'b0);
    chk("irq masked", 1'b0, irq);
    host.rd_reg(rfc_pkg::A_IRQ_STAT, v, r);
    chk("irq status", 2'h2, v[1:0]);
    host.wr_reg(rfc_pkg::A_IRQ_MASK, 32'h00000003, r);
    repeat (2) @(posedge clk);
    chk("irq raised", 1'b1, irq);
    host.wr_reg(rfc_pkg::A_IRQ_STAT, 32'h00000002, r);
    repeat (2) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    host.wr_reg(8'h40, 32'h00000000, r);
    chk("unmapped", rfc_pkg::RESP_SLVERR, r);
    host.rd_reg(8'h40, v, r);
    chk("unmapped read", {rfc_pkg::RESP_SLVERR, 32'h0000_0000}, {r, v});
    close_out();
  end
endmodule // rf_configuration_command_tb
